// ===== pkg/stm_pkg.sv
// constants, state type and code function for the safe torque off monitor
package stm_pkg;

  localparam int unsigned CODE_W       = 8;

  // object subindices
  localparam logic [7:0]  SUB_COUNT    = 8'h00;
  localparam logic [7:0]  SUB_STATE    = 8'h01;
  localparam logic [7:0]  SUB_RESET    = 8'h02;

  // object values
  localparam logic [7:0]  ENTRY_COUNT  = 8'h02;
  localparam logic [7:0]  RESET_CMD    = 8'h01;

  // state codes reported to software
  localparam logic [7:0]  CODE_BLOCKED = 8'h00;
  localparam logic [7:0]  CODE_ERROR   = 8'h01;
  localparam logic [7:0]  CODE_PERMIT  = 8'h10;
  localparam logic [7:0]  CODE_PWRDN   = 8'h11;

  typedef enum logic [1:0] {
    ST_PWRDN,
    ST_ERROR,
    ST_BLOCKED,
    ST_PERMIT
  } stm_state_e;

  function automatic logic [7:0] stm_state_code(input stm_state_e st);
    logic [7:0] code;
    code = CODE_PWRDN;
    case (st)
      ST_ERROR:   code = CODE_ERROR;
      ST_BLOCKED: code = CODE_BLOCKED;
      ST_PERMIT:  code = CODE_PERMIT;
      default:    code = CODE_PWRDN;
    endcase
    return code;
  endfunction : stm_state_code

endpackage : stm_pkg

// ===== pkg/stm_in_if.sv
// filtered enable inputs passed from the synchroniser to the monitor
`timescale 1ns/1ns
interface stm_in_if;
  logic ena_a;
  logic ena_b;
  modport src (output ena_a, output ena_b);
  modport dst (input ena_a, input ena_b);
endinterface : stm_in_if

// ===== verilog/stm_in_sync.sv
// three-stage synchroniser and agreement filter for the two enable pins
`timescale 1ns/1ns
module stm_in_sync (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic raw_a,
  input  wire logic raw_b,
  stm_in_if.src     sync
);

  logic [2:0] sh_a_reg;
  logic [2:0] sh_b_reg;
  logic       ena_a_reg;
  logic       ena_b_reg;

  // stage 0 feeds only stage 1; the filter looks at stages 1 and 2
  wire agree_a = (sh_a_reg[1] == sh_a_reg[2]);
  wire agree_b = (sh_b_reg[1] == sh_b_reg[2]);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_a_reg  <= 3'h0;
      sh_b_reg  <= 3'h0;
      ena_a_reg <= 1'b0;
      ena_b_reg <= 1'b0;
    end else begin
      sh_a_reg  <= {sh_a_reg[1:0], raw_a};
      sh_b_reg  <= {sh_b_reg[1:0], raw_b};
      if (agree_a) ena_a_reg <= sh_a_reg[2];
      if (agree_b) ena_b_reg <= sh_b_reg[2];
    end
  end

  assign sync.ena_a = ena_a_reg;
  assign sync.ena_b = ena_b_reg;

endmodule : stm_in_sync

// ===== verilog/stm_monitor.sv
// safe torque off monitor: state machine, object access, indicators
// Functional notes
// - torque needs both redundant enable inputs active
// - state readable as 8-bit code 0/1/16/17
// - writing one to reset object pulses reset
// - reset pulse in error gives blocked, code 0
// - both inputs active in blocked gives permitted
// - permitted: fault-free output high, status low
// - digital outputs and lamps show same values
// - entry count two readable at subindex zero
// - drive operation allowed only when torque permitted
// - entering error raises emergency message request
`timescale 1ns/1ns
module stm_monitor #(
  parameter int unsigned CODE_BITS = 8
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        safety_input_a,
  input  wire logic        safety_input_b,
  input  wire logic [7:0]  obj_sub,
  input  wire logic        obj_rd,
  input  wire logic        obj_wr,
  input  wire logic [7:0]  obj_wdata,
  output logic      [7:0]  obj_rdata,
  output logic             obj_rvalid,
  output logic             obj_err,
  output logic             status_out,
  output logic             no_error_out,
  output logic             status_led,
  output logic             no_error_led,
  output logic             drive_op_allow,
  output logic             emcy_req
);
  import stm_pkg::*;

  if (CODE_BITS != stm_pkg::CODE_W) begin : g_bad_width
    $error("stm_monitor: CODE_BITS must be 8");
  end

  stm_in_if in_if ();

  stm_in_sync u_sync (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .raw_a   (safety_input_a),
    .raw_b   (safety_input_b),
    .sync    (in_if)
  );

  stm_state_e state_reg;
  stm_state_e state_next;
  logic       rst_pulse_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       rvalid_reg;
  logic       err_reg;
  logic       err_next;
  logic       status_reg;
  logic       no_error_reg;
  logic       allow_reg;
  logic       emcy_reg;

  // torque is only possible with both channels active
  wire both_on    = in_if.ena_a & in_if.ena_b;
  wire hit_count  = (obj_sub == SUB_COUNT);
  wire hit_state  = (obj_sub == SUB_STATE);
  wire hit_reset  = (obj_sub == SUB_RESET);
  // any other value is ignored so a stray write cannot clear an error
  wire reset_cmd  = obj_wr & hit_reset & (obj_wdata == RESET_CMD);
  wire [7:0] state_code = stm_state_code(state_reg);

  // object read decode
  always_comb begin
    rdata_next = 8'h00;
    err_next   = 1'b0;
    if (obj_rd && hit_count) begin
      rdata_next = ENTRY_COUNT;
    end else if (obj_rd && hit_state) begin
      rdata_next = state_code;
    end else if (obj_rd) begin
      err_next   = 1'b1;
    end else if (obj_wr && !hit_reset) begin
      err_next   = 1'b1;
    end
  end

  // safety state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_PWRDN: begin
        state_next = ST_ERROR;
      end
      ST_ERROR: begin
        if (rst_pulse_reg) begin
          state_next = ST_BLOCKED;
        end else begin
          state_next = ST_ERROR;
        end
      end
      ST_BLOCKED: begin
        if (both_on) begin
          state_next = ST_PERMIT;
        end
      end
      ST_PERMIT: begin
        if (!both_on) begin
          state_next = ST_ERROR;
        end
      end
      default: begin
        state_next = ST_ERROR;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg     <= ST_PWRDN;
      rst_pulse_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      rst_pulse_reg <= reset_cmd;
    end
  end

  // indicators follow state_next so they change with state_reg
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_reg   <= 1'b1;
      no_error_reg <= 1'b0;
      allow_reg    <= 1'b0;
      emcy_reg     <= 1'b0;
    end else begin
      status_reg   <= (state_next != ST_PERMIT);
      no_error_reg <= (state_next == ST_PERMIT) || (state_next == ST_BLOCKED);
      allow_reg    <= (state_next == ST_PERMIT);
      emcy_reg     <= (state_next == ST_ERROR) && (state_reg != ST_ERROR);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
      err_reg    <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= obj_rd;
      err_reg    <= err_next;
    end
  end

  assign obj_rdata      = rdata_reg;
  assign obj_rvalid     = rvalid_reg;
  assign obj_err        = err_reg;
  // one register drives both pin and lamp so they can never disagree
  assign status_out     = status_reg;
  assign status_led     = status_reg;
  assign no_error_out   = no_error_reg;
  assign no_error_led   = no_error_reg;
  assign drive_op_allow = allow_reg;
  assign emcy_req       = emcy_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_state_code_read: assert property (
    obj_rd && hit_state |=> obj_rvalid && (obj_rdata == $past(state_code))
  ) else $error("state code readback wrong");

  a_reset_pulse_gen: assert property (
    reset_cmd |-> ##1 rst_pulse_reg ##1 (rst_pulse_reg == $past(reset_cmd))
  ) else $error("reset write did not pulse");

  a_error_hold_off: assert property (
    (state_reg == ST_ERROR) && !rst_pulse_reg |=> (state_reg == ST_ERROR)
  ) else $error("error state left without reset");

  a_reset_to_blocked: assert property (
    (state_reg == ST_ERROR) && rst_pulse_reg |=> (state_code == CODE_BLOCKED)
  ) else $error("reset in error did not give code 0");

  a_permit_entry: assert property (
    (state_reg == ST_BLOCKED) && both_on |=> (state_code == CODE_PERMIT) && no_error_out
  ) else $error("both inputs did not permit torque");

  a_permit_outputs: assert property (
    (state_reg == ST_PERMIT) |-> no_error_out && !status_out
  ) else $error("permitted state indicators wrong");

  a_led_mirror: assert property (
    (status_led == status_out) && (no_error_led == no_error_out)
  ) else $error("lamp and output differ");

  a_entry_count: assert property (
    obj_rd && hit_count |=> obj_rvalid && (obj_rdata == ENTRY_COUNT) && !obj_err
  ) else $error("entry count read wrong");

  a_drive_gate: assert property (
    drive_op_allow == (state_reg == ST_PERMIT)
  ) else $error("drive allowed outside permitted state");

  a_emcy_raise: assert property (
    (state_reg != ST_ERROR) ##1 (state_reg == ST_ERROR) |-> emcy_req ##1 !emcy_req
  ) else $error("emergency request missing on error entry");

  a_input_loss: assert property (
    (state_reg == ST_PERMIT) && !both_on |=> (state_code == CODE_ERROR) && !no_error_out
      && !drive_op_allow
  ) else $error("input loss did not give error");

  // one channel alone must never release torque
  a_one_input_block: assert property (
    (state_reg == ST_BLOCKED) && !both_on |=> (state_reg == ST_BLOCKED)
  ) else $error("single input left blocked state");

  a_reset_value_only: assert property (
    obj_wr && hit_reset && (obj_wdata != RESET_CMD) |=> !rst_pulse_reg
  ) else $error("reset pulse from wrong value");

endmodule : stm_monitor

// ===== verif/stm_safety_model.sv
// external safety circuit model driving the two redundant enable pins
`timescale 1ns/1ns
module stm_safety_model (
  input  wire logic sys_clk,
  input  wire logic req_a,
  input  wire logic req_b,
  output logic      pin_a,
  output logic      pin_b
);
  // pins follow each clock edge 3 and 5 ns later, so they move between edges with some skew
  always @(posedge sys_clk) begin
    pin_a <= #3 req_a;
    pin_b <= #5 req_b;
  end
endmodule : stm_safety_model

// ===== verif/testbench.sv
// self-checking bench for the safe torque off monitor
`timescale 1ns/1ns
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module testbench;
  import stm_pkg::*;
  logic       sys_clk, rst_b, req_a, req_b, obj_rd, obj_wr;
  logic [7:0] obj_sub, obj_wdata, obj_rdata, rd_d, r;
  logic       obj_rvalid, obj_err, status_out, no_error_out, status_led, no_error_led;
  logic       drive_op_allow, emcy_req, rd_v, rd_e;
  wire        pin_a, pin_b;
  int         err_total, total_checks, seed, emcy_cnt, i;

  stm_safety_model stm_safety_model_inst (.sys_clk(sys_clk), .req_a(req_a), .req_b(req_b),
    .pin_a(pin_a), .pin_b(pin_b));
  stm_monitor #(.CODE_BITS(8)) stm_monitor_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .safety_input_a(pin_a), .safety_input_b(pin_b), .obj_sub(obj_sub), .obj_rd(obj_rd),
    .obj_wr(obj_wr), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_rvalid(obj_rvalid),
    .obj_err(obj_err), .status_out(status_out), .no_error_out(no_error_out),
    .status_led(status_led), .no_error_led(no_error_led), .drive_op_allow(drive_op_allow),
    .emcy_req(emcy_req));

  always #4 sys_clk = ~sys_clk;
  // the emergency request is a one-cycle pulse, so count it on every edge
  always @(posedge sys_clk) if (emcy_req === 1'b1) emcy_cnt++;

  function automatic logic [2:0] exp_flags(input logic [7:0] code);
    return {code != CODE_PERMIT, code == CODE_BLOCKED || code == CODE_PERMIT,
            code == CODE_PERMIT};
  endfunction : exp_flags

  task automatic stop_test;
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic obj_cycle(input logic wr, input logic [7:0] sub, input logic [7:0] wd);
    @(posedge sys_clk);
    obj_rd <= !wr; obj_wr <= wr; obj_sub <= sub; obj_wdata <= wd;
    @(posedge sys_clk);
    obj_rd <= 1'b0; obj_wr <= 1'b0;
    #1 rd_d = obj_rdata; rd_v = obj_rvalid; rd_e = obj_err;
  endtask : obj_cycle

  task automatic read_chk(input logic [7:0] sub, input logic [7:0] exp, input logic e);
    obj_cycle(1'b0, sub, 8'h00);
    `CHK(rd_v, 1'b1)
    `CHK(rd_d, exp)
    `CHK(rd_e, e)
  endtask : read_chk

  task automatic out_chk(input logic [7:0] code);
    read_chk(SUB_STATE, code, 1'b0);
    `CHK({status_out, no_error_out, drive_op_allow}, exp_flags(code))
    `CHK({status_led, no_error_led, drive_op_allow}, exp_flags(code))
  endtask : out_chk

  task automatic set_pins(input logic a, input logic b);
    @(posedge sys_clk);
    req_a <= a; req_b <= b;
    repeat (8) @(posedge sys_clk);
    #1;
  endtask : set_pins

  initial begin
    #100000;
    err_total++;
    stop_test();
  end

  initial begin
    sys_clk = 0; rst_b = 0; req_a = 0; req_b = 0; obj_rd = 0; obj_wr = 0;
    obj_sub = 0; obj_wdata = 0; err_total = 0; total_checks = 0; emcy_cnt = 0;
    seed = 49065;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    // a read taken at the first edge after release still sees powerdown
    obj_rd <= 1'b1;
    obj_sub <= SUB_STATE;
    @(posedge sys_clk);
    obj_rd <= 1'b0;
    #1;
    `CHK(obj_rvalid, 1'b1)
    `CHK(obj_rdata, CODE_PWRDN)
    for (i = 0; i < 4; i++) begin
      out_chk(CODE_ERROR);
      `CHK(emcy_cnt, i + 1)
      read_chk(SUB_COUNT, ENTRY_COUNT, 1'b0);
      r = 8'h03 + ($random(seed) & 8'h7f);
      read_chk(r, 8'h00, 1'b1);
      read_chk(SUB_RESET, 8'h00, 1'b1);
      obj_cycle(1'b1, SUB_STATE, RESET_CMD);
      `CHK(rd_e, 1'b1)
      set_pins(1'b1, 1'b1);
      out_chk(CODE_ERROR);
      set_pins(1'b0, 1'b0);
      r = 8'h02 | ($random(seed) & 8'hfe);
      obj_cycle(1'b1, SUB_RESET, r);
      out_chk(CODE_ERROR);
      obj_cycle(1'b1, SUB_RESET, RESET_CMD);
      `CHK(rd_e, 1'b0)
      out_chk(CODE_BLOCKED);
      r = $random(seed) & 8'h01;
      set_pins(r[0], !r[0]);
      out_chk(CODE_BLOCKED);
      set_pins(1'b1, 1'b1);
      out_chk(CODE_PERMIT);
      `CHK(emcy_cnt, i + 1)
      r = 8'h01 + ($random(seed) & 8'h01) + ((i == 3) ? 8'h01 : 8'h00);
      set_pins(!r[0], !r[1]);
    end
    out_chk(CODE_ERROR);
    `CHK(emcy_cnt, 5)
    stop_test();
  end
endmodule : testbench
